// ==== verilog/tmm_ctrl.sv ====
`timescale 1ns/1ps
module tmm_ctrl
  import tmm_pkg::*;
#(
  parameter logic HAS_7TRK = 1'b1
)
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // channel command
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_mod,
  input  wire logic       cmd_chained,
  input  wire logic       chain_end,
  output logic            cmd_ready,
  // status to channel
  output logic            init_valid,
  output logic [7:0]      init_status,
  output logic            final_valid,
  output logic [7:0]      final_status,
  output logic            busy,
  output logic            sense_clear,
  // tape drive pins
  input  wire logic       gap_seen,
  input  wire logic       tmark_seen,
  input  wire logic       at_load_point,
  input  wire logic       eot_seen,
  input  wire logic       erase_bad,
  input  wire logic       drive_has_nrzi,
  output logic            move_fwd,
  output logic            move_bwd,
  output logic            erase_head_on,
  output logic            write_dc_on,
  output logic            read_verify_on,
  output logic            drive_mode_load,
  output logic            drive_mode_pe,
  // mode state
  input  wire logic       panel_diag_sw,
  input  wire logic       ctl_has_nrzi,
  output logic [7:0]      mode7_r,
  output logic            mode9_pe_r,
  output logic            diag_r,
  // write path corruption
  input  wire logic [8:0] wr_in,
  input  wire logic [8:0] wr_next_ones,
  input  wire logic [1:0] wr_rec,
  output logic [8:0]      wr_out
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_RUN = 4'h2, S_PAST = 4'h4, S_ERASE = 4'h8
  } tmm_state_e;

  tmm_state_e state_r, state_nxt;
  tmm_kind_e  kind, kind_r, kind_nxt;
  logic is_nop, is_m7, is_m9, is_dms;
  logic [5:0] raw, syn;
  logic gap, tm, lp, end_of_tape_marker, ebad, dnrzi;
  logic last_erg_r, last_erg_nxt;
  logic [7:0]  mode7_nxt;
  logic        mode9_nxt, diag_nxt;
  logic [15:0] cyc_r, cyc_nxt;
  logic [5:0]  ten_r, ten_nxt;
  logic        eotf_r, eotf_nxt, fail_r, fail_nxt;
  logic        ld, ld_pe;
  logic [7:0]  ist, fst;
  logic        iv, fv, sclr;
  logic [7:0]  fst_r;
  logic        fv_r, iv_r;
  logic [7:0]  ist_r;
  logic        sclr_r;

  tmm_decode u_dec (
    .code   (cmd_code),
    .kind   (kind),
    .is_nop (is_nop),
    .is_m7  (is_m7),
    .is_m9  (is_m9),
    .is_dms (is_dms)
  );

  assign raw = {drive_has_nrzi, erase_bad, eot_seen, at_load_point,
                tmark_seen, gap_seen};
  tmm_sync u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     (raw),
    .dout    (syn)
  );
  assign {dnrzi, ebad, end_of_tape_marker, lp, tm, gap} = syn;

  // status byte builder shared by all endings
  function automatic logic [7:0] st(input logic che, input logic cue,
                                    input logic de, input logic uc,
                                    input logic ue);
    logic [7:0] b;
    b = ST_NONE;
    b[ST_CHE] = che;
    b[ST_CUE] = cue;
    b[ST_DE]  = de;
    b[ST_UC]  = uc;
    b[ST_UE]  = ue;
    return b;
  endfunction

  assign cmd_ready = (state_r == S_IDLE);

  // command sequencing and endings
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    last_erg_nxt = last_erg_r;
    mode7_nxt = mode7_r;
    mode9_nxt = mode9_pe_r;
    diag_nxt = diag_r;
    cyc_nxt = cyc_r;
    ten_nxt = ten_r;
    eotf_nxt = eotf_r;
    fail_nxt = fail_r;
    ld = 1'b0;
    ld_pe = 1'b0;
    iv = 1'b0;
    ist = ST_NONE;
    fv = 1'b0;
    fst = ST_NONE;
    sclr = 1'b0;
    // chain end drops latch only with panel switch off
    if (chain_end && !panel_diag_sw)
      diag_nxt = 1'b0;
    case (state_r)
      S_IDLE:
      begin
        if (cmd_valid)
        begin
          iv = 1'b1;
          kind_nxt = kind;
          last_erg_nxt = (kind == TMM_K_ERG);
          eotf_nxt = 1'b0;
          fail_nxt = 1'b0;
          if (kind == TMM_K_IMM)
          begin
            ist = st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
            if (is_m7)
            begin
              diag_nxt = 1'b0;
              if (HAS_7TRK)
                mode7_nxt = cmd_mod;
              else
                sclr = 1'b1;
            end
            else if (is_m9)
            begin
              sclr = 1'b1;
              if ((cmd_mod[0] || ctl_has_nrzi) &&
                  (cmd_mod[0] || !lp || dnrzi))
              begin
                mode9_nxt = cmd_mod[0];
                ld = lp;
                ld_pe = cmd_mod[0];
              end
            end
            else if (is_dms)
              diag_nxt = 1'b1;
            // no operation leaves the mode registers, diag latch and sense alone
          end
          else if (kind == TMM_K_BAD ||
                   (kind == TMM_K_SEC && !(cmd_chained && last_erg_r)))
            ist = st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
          else
          begin
            ist = st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            cyc_nxt = 16'h0000;
            ten_nxt = 6'((lp ? ERG_LP_TENTHS : ERG_TENTHS));
            state_nxt = (kind == TMM_K_ERG) ? S_ERASE : S_RUN;
          end
        end
      end
      S_ERASE:
      begin
        if (end_of_tape_marker)
          eotf_nxt = 1'b1;
        if (ebad)
          fail_nxt = 1'b1;
        if (cyc_r == TENTH_CYC_W - 16'h0001)
        begin
          cyc_nxt = 16'h0000;
          ten_nxt = ten_r - 6'h01;
          if (ten_r == 6'h01)
          begin
            fv = 1'b1;
            fst = st(1'b0, eotf_r | end_of_tape_marker | fail_r, 1'b1,
                     fail_r, eotf_r | end_of_tape_marker);
            state_nxt = S_IDLE;
          end
        end
        else
          cyc_nxt = cyc_r + 16'h0001;
      end
      S_RUN:
      begin
        case (kind_r)
          TMM_K_FBS:
            if (tm || gap)
            begin
              fv = 1'b1;
              fst = st(1'b0, tm, 1'b1, 1'b0, tm);
              state_nxt = S_IDLE;
            end
          TMM_K_BBS:
            if (lp || tm || gap)
            begin
              fv = 1'b1;
              fst = st(1'b0, lp | tm, 1'b1, lp, tm & !lp);
              state_nxt = S_IDLE;
            end
          TMM_K_FFS:
            if (tm)
              state_nxt = S_PAST;
          TMM_K_BFS:
            if (lp || tm)
            begin
              fv = 1'b1;
              fst = st(1'b0, lp, 1'b1, lp, 1'b0);
              state_nxt = S_IDLE;
            end
          TMM_K_SEC:
            if (end_of_tape_marker)
            begin
              fv = 1'b1;
              fst = st(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
              state_nxt = S_IDLE;
            end
          default: state_nxt = S_IDLE;
        endcase
      end
      S_PAST:
      begin
        // past the mark, the next gap ends the skip
        if (gap)
        begin
          fv = 1'b1;
          fst = st(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= S_IDLE;
      kind_r <= TMM_K_IMM;
      last_erg_r <= 1'b0;
      mode7_r <= 8'h00;
      mode9_pe_r <= 1'b1;
      diag_r <= 1'b0;
      cyc_r <= 16'h0000;
      ten_r <= 6'h00;
      eotf_r <= 1'b0;
      fail_r <= 1'b0;
      iv_r <= 1'b0;
      ist_r <= ST_NONE;
      fv_r <= 1'b0;
      fst_r <= ST_NONE;
      sclr_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      last_erg_r <= last_erg_nxt;
      mode7_r <= mode7_nxt;
      mode9_pe_r <= mode9_nxt;
      diag_r <= diag_nxt;
      cyc_r <= cyc_nxt;
      ten_r <= ten_nxt;
      eotf_r <= eotf_nxt;
      fail_r <= fail_nxt;
      iv_r <= iv;
      ist_r <= ist;
      fv_r <= fv;
      fst_r <= fst;
      sclr_r <= sclr;
    end
  end

  // registered status outputs
  assign init_valid = iv_r;
  assign init_status = ist_r;
  assign final_valid = fv_r;
  assign final_status = fst_r;
  assign sense_clear = sclr_r;
  assign busy = (state_r != S_IDLE);

  // motion and head drive; immediates never move tape
  assign move_fwd = (state_r == S_ERASE) || (state_r == S_PAST) ||
                    ((state_r == S_RUN) &&
                     (kind_r == TMM_K_FBS || kind_r == TMM_K_FFS ||
                      kind_r == TMM_K_SEC));
  assign move_bwd = (state_r == S_RUN) &&
                    (kind_r == TMM_K_BBS || kind_r == TMM_K_BFS);
  assign erase_head_on = (state_r == S_ERASE) ||
                         ((state_r == S_RUN) && kind_r == TMM_K_SEC);
  assign write_dc_on = erase_head_on;
  assign read_verify_on = (state_r == S_ERASE);
  assign drive_mode_load = ld;
  assign drive_mode_pe = ld_pe; // drive itself reverts to pe

  // diagnostic corruption of write data
  always_comb
  begin
    wr_out = wr_in;
    if (diag_r)
    begin
      if (mode9_pe_r && wr_rec == 2'h0)
        wr_out = wr_in & ~wr_next_ones;
      else if (wr_rec == 2'h1)
        wr_out = {1'b0, wr_in[7:0]};
      else if (wr_rec == 2'h2)
        wr_out = {wr_in[8:7], 1'b0, wr_in[5:0]};
    end
  end

  a_imm_status: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_ready && cmd_valid && kind == TMM_K_IMM) |=>
    (init_valid && init_status[ST_CHE] && init_status[ST_DE]))
    else $error("immediate status wrong");
  a_sec_reject: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_ready && cmd_valid && kind == TMM_K_SEC && !last_erg_r) |=>
    (init_status[ST_UC] && !busy))
    else $error("unchained secure erase taken");
  a_no_motion: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_ready && cmd_valid && kind == TMM_K_IMM) |=>
    (!move_fwd && !move_bwd))
    else $error("immediate moved tape");
  a_dms_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_ready && cmd_valid && is_dms) |=> diag_r)
    else $error("diag latch not set");
  a_m9_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_ready && cmd_valid && is_m9) |=> sense_clear)
    else $error("nine track mode set kept sense");
  a_fbs_gap_end: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == S_RUN && kind_r == TMM_K_FBS && gap && !tm) |=>
    (final_valid && final_status == 8'h04 && !busy))
    else $error("block skip gap ending wrong");
endmodule

// ==== verilog/tmm_pkg.sv ====
package tmm_pkg;
  // status byte bit positions
  localparam int ST_UE  = 0;
  localparam int ST_UC  = 1;
  localparam int ST_DE  = 2;
  localparam int ST_CHE = 3;
  localparam int ST_CUE = 5;
  localparam logic [7:0] ST_NONE = 8'h00;
  // command code table defaults
  localparam logic [7:0] C_FBS = 8'h3f;
  localparam logic [7:0] C_BBS = 8'h27;
  localparam logic [7:0] C_FFS = 8'h3e;
  localparam logic [7:0] C_BFS = 8'h2f;
  localparam logic [7:0] C_ERG = 8'h17;
  localparam logic [7:0] C_SEC = 8'h97;
  localparam logic [7:0] C_NOP = 8'h03;
  localparam logic [7:0] C_M7  = 8'h13;
  localparam logic [7:0] C_M9  = 8'hc3;
  localparam logic [7:0] C_DMS = 8'h0b;
  // command kinds
  typedef enum logic [2:0] {
    TMM_K_FBS = 3'h0, TMM_K_BBS = 3'h1, TMM_K_FFS = 3'h2,
    TMM_K_BFS = 3'h3, TMM_K_ERG = 3'h4, TMM_K_SEC = 3'h5,
    TMM_K_IMM = 3'h6, TMM_K_BAD = 3'h7
  } tmm_kind_e;
  // gap erase lengths in tenths of an inch, tape travel time per tenth in us
  localparam int ERG_TENTHS    = 36;
  localparam int ERG_LP_TENTHS = 42;
  localparam int CLK_MHZ       = 50;
  localparam int TENTH_US      = 800;
  localparam int TENTH_CYC     = TENTH_US * CLK_MHZ;
  localparam logic [15:0] TENTH_CYC_W = 16'(TENTH_CYC);
endpackage

// ==== verilog/tmm_decode.sv ====
`timescale 1ns/1ps
module tmm_decode
  import tmm_pkg::*;
(
  // command in
  input  wire logic [7:0] code,
  // decoded class
  output tmm_kind_e        kind,
  output logic             is_nop,
  output logic             is_m7,
  output logic             is_m9,
  output logic             is_dms
);
  // table lookup of command code
  always_comb
  begin
    is_nop = (code == C_NOP);
    is_m7  = (code == C_M7);
    is_m9  = (code == C_M9);
    is_dms = (code == C_DMS);
    case (code)
      C_FBS:   kind = TMM_K_FBS;
      C_BBS:   kind = TMM_K_BBS;
      C_FFS:   kind = TMM_K_FFS;
      C_BFS:   kind = TMM_K_BFS;
      C_ERG:   kind = TMM_K_ERG;
      C_SEC:   kind = TMM_K_SEC;
      C_NOP, C_M7, C_M9, C_DMS: kind = TMM_K_IMM;
      default: kind = TMM_K_BAD;
    endcase
  end
endmodule

// ==== verilog/tmm_sync.sv ====
`timescale 1ns/1ps
module tmm_sync
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // level in and out
  input  wire logic [5:0] din,
  output logic      [5:0] dout
);
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  // two flops, first flop read only by second
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end
  assign dout = s2_r;
endmodule

// ==== tb/tmm_tape_model.sv ====
`timescale 1ns/1ps
module tmm_tape_model
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // motion and mode from the controller
  input  wire logic       move_fwd,
  input  wire logic       move_bwd,
  input  wire logic       drive_mode_load,
  input  wire logic       drive_mode_pe,
  // tape layout: 0 gap, 1 mark then gap, 2 load point, 3 end marker
  input  wire logic [1:0] scen,
  input  wire logic [3:0] dly,
  // sensed events
  output logic            gap_seen,
  output logic            tmark_seen,
  output logic            at_load_point,
  output logic            eot_seen,
  output logic            pe_mode_r
);
  logic [4:0] cnt_r;
  logic [4:0] d;
  logic       mv;
  logic       lp_hit;
  assign mv = move_fwd | move_bwd;
  assign d = {1'b0, dly};
  assign lp_hit = move_bwd && scen == 2'h2 && cnt_r >= d;
  // events only while tape moves; a stopped tape shows no mark, gap or end marker
  assign tmark_seen = mv && scen == 2'h1 && cnt_r >= d && cnt_r < d + 5'h4;
  assign gap_seen = mv && ((scen == 2'h0 && cnt_r >= d)
                    || (scen == 2'h1 && cnt_r >= d + 5'h6));
  assign eot_seen = mv && scen == 2'h3 && cnt_r >= d;
  // cycles into the current motion, saturating
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      cnt_r <= 5'h00;
    else
      cnt_r <= !mv ? 5'h00 : (cnt_r == 5'h1f ? cnt_r : cnt_r + 5'h01);
  // load point held until tape runs forward; pe on every arrival
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      at_load_point <= 1'b0;
      pe_mode_r <= 1'b1;
    end
    else
    begin
      if (move_fwd)
        at_load_point <= 1'b0;
      else if (lp_hit)
        at_load_point <= 1'b1;
      if (lp_hit && !at_load_point)
        pe_mode_r <= 1'b1;
      else if (drive_mode_load)
        pe_mode_r <= drive_mode_pe;
    end
endmodule

// ==== tb/tape_motion_and_mode_commands_test.sv ====
`timescale 1ns/1ps
module tape_motion_and_mode_commands_test;
  import tmm_pkg::*;
  logic       ref_clk = 0, resetn = 0, chain_end = 0;
  logic       cmd_valid = 0, cmd_chained = 0;
  logic [7:0] cmd_code = 8'h00, cmd_mod = 8'h00;
  logic       panel_diag_sw = 0, ctl_has_nrzi = 1;
  logic [8:0] wr_in = 9'h000, wr_next_ones = 9'h000;
  logic [1:0] wr_rec = 2'h0, scen = 2'h0;
  logic [3:0] dly = 4'h5;
  logic       cmd_ready, init_valid, final_valid, busy, sense_clear;
  logic [7:0] init_status, final_status, mode7_r, st, m;
  logic       gap_seen, tmark_seen, at_load_point, eot_seen;
  logic       move_fwd, move_bwd, erase_head_on, write_dc_on;
  logic       read_verify_on, drive_mode_load, drive_mode_pe;
  logic       mode9_pe_r, diag_r, pe_mode_r;
  logic [8:0] wr_out;
  int         fails = 0, n_checks = 0, n_sc = 0, n;

  tmm_ctrl uut (.ref_clk, .resetn, .cmd_valid, .cmd_code, .cmd_mod,
    .cmd_chained, .chain_end, .cmd_ready, .init_valid, .init_status,
    .final_valid, .final_status, .busy, .sense_clear, .gap_seen,
    .tmark_seen, .at_load_point, .eot_seen, .erase_bad(1'b0),
    .drive_has_nrzi(1'b1), .move_fwd, .move_bwd, .erase_head_on,
    .write_dc_on, .read_verify_on, .drive_mode_load, .drive_mode_pe,
    .panel_diag_sw, .ctl_has_nrzi, .mode7_r, .mode9_pe_r, .diag_r,
    .wr_in, .wr_next_ones, .wr_rec, .wr_out);
  tmm_tape_model drive (.ref_clk, .resetn, .move_fwd, .move_bwd,
    .drive_mode_load, .drive_mode_pe, .scen, .dly, .gap_seen,
    .tmark_seen, .at_load_point, .eot_seen, .pe_mode_r);

  always #10 ref_clk = ~ref_clk;
  // sense clears are pulses, so count them as they pass
  always @(posedge ref_clk)
    if (sense_clear === 1'b1)
      n_sc++;

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // offer one command; st is ff when no initial status came
  task automatic issue(input logic [7:0] c, input logic [7:0] md,
                       input logic ch);
    @(posedge ref_clk);
    cmd_code <= c;
    cmd_mod <= md;
    cmd_chained <= ch;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    st = 8'hff;
    repeat (4)
    begin
      #1;
      if (init_valid === 1'b1 && st === 8'hff)
        st = init_status;
      @(posedge ref_clk);
    end
  endtask

  // watch a fixed span for final status; ff means none expected
  task automatic fin(input logic [7:0] exp);
    logic [7:0] f;
    f = 8'hff;
    repeat (60)
    begin
      @(posedge ref_clk);
      #1;
      if (final_valid === 1'b1)
        f = final_status;
    end
    chk(f, exp);
  endtask

  task automatic motion(input logic [7:0] c, input logic [1:0] s,
                        input logic [7:0] e, input logic [1:0] dir);
    scen <= s;
    dly <= 4'($urandom_range(9, 5));
    issue(c, 8'h00, 1'b0);
    #1;
    chk(st, 9'h008);
    chk({move_fwd, move_bwd}, dir);
    fin(e);
  endtask

  function automatic logic [8:0] exp_wr(input logic [8:0] w,
    input logic [8:0] o, input logic [1:0] r, input logic dg);
    if (!dg)
      return w;
    if (r == 2'h0)
      return w & ~o;
    return (r == 2'h1) ? (w & 9'h0ff) : (w & 9'h1bf);
  endfunction

  // random write words through recording modes 0, 1 and 2
  task automatic wr_sweep(input logic dg);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      wr_in <= 9'($urandom);
      wr_next_ones <= 9'($urandom);
      wr_rec <= 2'(i % 3);
      @(posedge ref_clk);
      #1;
      chk(wr_out, exp_wr(wr_in, wr_next_ones, wr_rec, dg));
    end
  endtask

  task automatic pulse_end();
    @(posedge ref_clk);
    chain_end <= 1'b1;
    @(posedge ref_clk);
    chain_end <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // a hang anywhere ends the run as a mismatch
  initial
  begin
    #2ms;
    fails++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(16796));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    motion(C_FBS, 2'h0, 8'h04, 2'h2);
    motion(C_FBS, 2'h1, 8'h25, 2'h2);
    motion(C_BBS, 2'h0, 8'h04, 2'h1);
    motion(C_BBS, 2'h1, 8'h25, 2'h1);
    motion(C_FFS, 2'h1, 8'h04, 2'h2);
    motion(C_BFS, 2'h1, 8'h04, 2'h1);
    motion(C_BFS, 2'h2, 8'h26, 2'h1);
    // leave load point first, else the backspace ends at once
    motion(C_FBS, 2'h0, 8'h04, 2'h2);
    motion(C_BBS, 2'h2, 8'h26, 2'h1);
    // immediates, tape resting at load point
    n = n_sc;
    issue(C_NOP, 8'h00, 1'b0);
    chk(st, 9'h00c);
    chk(9'(n_sc - n), 9'h000);
    m = 8'($urandom);
    issue(C_M7, m, 1'b0);
    chk(st, 9'h00c);
    chk(mode7_r, m);
    issue(C_NOP, 8'h00, 1'b0);
    chk(mode7_r, m);
    n = n_sc;
    issue(C_M9, 8'h00, 1'b0);
    chk({mode9_pe_r, pe_mode_r}, 9'h000);
    issue(C_M9, 8'h01, 1'b0);
    chk({mode9_pe_r, pe_mode_r}, 9'h003);
    chk(9'(n_sc - n), 9'h002);
    ctl_has_nrzi <= 1'b0;
    issue(C_M9, 8'h00, 1'b0);
    chk({mode9_pe_r, pe_mode_r}, 9'h003);
    chk(9'(n_sc - n), 9'h003);
    ctl_has_nrzi <= 1'b1;
    wr_sweep(1'b0);
    issue(C_DMS, 8'h00, 1'b0);
    chk(st, 9'h00c);
    wr_sweep(1'b1);
    pulse_end();
    chk(diag_r, 1'b0);
    panel_diag_sw <= 1'b1;
    issue(C_DMS, 8'h00, 1'b0);
    pulse_end();
    chk(diag_r, 1'b1);
    issue(C_M7, m, 1'b0);
    chk(diag_r, 1'b0);
    // refusals and the erase that outlasts the run
    issue(C_SEC, 8'h00, 1'b0);
    chk(st, 9'h002);
    fin(8'hff);
    issue(C_ERG, 8'h00, 1'b0);
    chk(st, 9'h008);
    chk({erase_head_on, write_dc_on, read_verify_on, busy}, 9'h00f);
    issue(C_NOP, 8'h00, 1'b0);
    chk(st, 9'h0ff);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk({busy, mode9_pe_r}, 9'h001);
    print_verdict();
  end
endmodule
